// *** rtl/lu_regs.sv ***
// The AHB-Lite interface to the registers was chosen for this implementation.
`include "lu_params.svh"

module lu_regs (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [7:0]  los_in,
	input  wire logic [7:0]  alarm_in,
	output lu_pkg::lu_line_s line,
	output logic             irq
);
	import lu_pkg::*;

	localparam lu_state_s ST_RST = '{hreadyout: 1'b1, default: '0};

	lu_state_s s;
	lu_state_s n;
	logic      take;
	logic      hit;
	logic      srst_busy;
	logic      srst_load;
	logic [5:0] aidx;
	logic [7:0] rd_clr;
	logic [7:0] w1c;
	logic [7:0] set_v;

	////////////////////////////////////////////////////////////////
	// Address decode

	assign take = hsel && hready && htrans[1];
	assign aidx = haddr[7:2];
	assign hit = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
	assign srst_busy = (s.srst_cnt != 9'h000);
	assign srst_load = s.wr_pend && (s.wr_idx == `LU_IDX_SRST);
	assign set_v = (alarm_in ^ s.alarm_status) & s.alarm_interrupt_mask;

	////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		n = s;
		rd_clr = 8'h00;
		w1c = 8'h00;
		n.los_status = los_in;
		n.alarm_status = alarm_in;
		n.hreadyout = 1'b1;
		n.hrdata = 32'h00000000;
		n.wr_pend = take && hwrite && hit;
		n.wr_idx = aidx;

		// Read data captured in the address phase
		if (take && !hwrite && hit) begin
			unique case (aidx)
				`LU_IDX_LOS:   n.hrdata[7:0] = s.los_status;
				`LU_IDX_AAO:   n.hrdata[7:0] = s.auto_all_ones_enable;
				`LU_IDX_GCFG:  n.hrdata[7:0] = s.global_configuration;
				`LU_IDX_TIDX:  n.hrdata[2:0] = s.template_channel_index;
				`LU_IDX_TSEL: begin
					n.hrdata[2:0] = s.template_select[s.template_channel_index];
				end
				`LU_IDX_HIZ:   n.hrdata[7:0] = s.driver_highz_control;
				`LU_IDX_ALST: begin
					n.hrdata[7:0] = s.alarm_status;
					rd_clr = 8'hFF;
				end
				`LU_IDX_MASK:  n.hrdata[7:0] = s.alarm_interrupt_mask;
				`LU_IDX_LATCH: n.hrdata[7:0] = s.alarm_interrupt_latch;
				default:       n.hrdata = 32'h00000000;
			endcase
		end

		// Writes land in the data phase
		if (s.wr_pend && !srst_busy) begin
			unique case (s.wr_idx)
				`LU_IDX_SRST:  n.srst_cnt = 9'(`LU_SRST_CYC);
				`LU_IDX_AAO:   n.auto_all_ones_enable = hwdata[7:0];
				`LU_IDX_GCFG:  n.global_configuration = hwdata[7:0] & `LU_GCFG_WMASK;
				`LU_IDX_TIDX:  n.template_channel_index = hwdata[2:0];
				`LU_IDX_TSEL: begin
					n.template_select[s.template_channel_index] = hwdata[2:0];
				end
				`LU_IDX_HIZ:   n.driver_highz_control = hwdata[7:0];
				`LU_IDX_MASK:  n.alarm_interrupt_mask = hwdata[7:0];
				`LU_IDX_LATCH: w1c = hwdata[7:0];
				default:       n.srst_cnt = s.srst_cnt;
			endcase
		end

		// Sticky latch, a new transition wins over a clear
		n.alarm_interrupt_latch = (s.alarm_interrupt_latch & ~(rd_clr | w1c)) | set_v;

		// Software reset holds every writable register at default
		// Defaults apply from the triggering write onward
		if (srst_busy || srst_load) begin
			if (srst_busy) begin
				n.srst_cnt = s.srst_cnt - 9'h001;
			end
			n.auto_all_ones_enable = `LU_RST8;
			n.global_configuration = `LU_RST8;
			n.template_channel_index = `LU_RST3;
			n.template_select = '0;
			n.driver_highz_control = `LU_RST8;
			n.alarm_interrupt_mask = `LU_RST8;
			n.alarm_interrupt_latch = `LU_RST8;
		end

		// Line side controls
		n.line.all_ones_tx = s.auto_all_ones_enable & s.los_status;
		n.line.alarm_insert = {8{s.global_configuration[`LU_B_AINS]}} & s.los_status;
		n.line.short_protect_disable = s.global_configuration[`LU_B_SPD];
		n.line.ami_select = s.global_configuration[`LU_B_AMI];
		n.line.jitter_depth_select = s.global_configuration[`LU_B_JDEP];
		n.line.jitter_bandwidth_select = s.global_configuration[`LU_B_JBW];
		n.line.ja_tx = s.global_configuration[`LU_JA_HI:`LU_JA_LO] == `LU_JA_TX;
		n.line.ja_rx = s.global_configuration[`LU_JA_HI:`LU_JA_LO] == `LU_JA_RX;
		n.line.template_code = s.template_select;
		n.line.driver_highz = s.driver_highz_control;
		n.irq = |s.alarm_interrupt_latch;
	end

	////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= ST_RST;
		end else if (ce) begin
			s <= n;
		end
	end

	assign hrdata = s.hrdata;
	assign hreadyout = s.hreadyout;
	assign hresp = 1'b0;
	assign line = s.line;
	assign irq = s.irq;

	////////////////////////////////////////////////////////////////
	// Checks

	logic [1:0] ce_hist;
	logic       ce_ok;
	logic       gcfg_wr;
	logic       hiz_wr;
	logic       alst_rd;
	logic       srst_go;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ce_hist <= 2'h0;
		end else begin
			ce_hist <= {ce_hist[0], ce};
		end
	end

	assign ce_ok = ce && (ce_hist == 2'h3);
	assign gcfg_wr = ce && s.wr_pend && !srst_busy && (s.wr_idx == `LU_IDX_GCFG);
	assign hiz_wr = ce && s.wr_pend && !srst_busy && (s.wr_idx == `LU_IDX_HIZ);
	assign alst_rd = ce && take && !hwrite && hit && (aidx == `LU_IDX_ALST);
	assign srst_go = ce && s.wr_pend && !srst_busy && (s.wr_idx == `LU_IDX_SRST);

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_ALL_ONES: assert property (ce_ok && !srst_busy |->
		line.all_ones_tx == ($past(los_in, 2) & $past(s.auto_all_ones_enable)))
		else $error("all ones output wrong");
	AST_ALARM_INS: assert property (ce_ok && !srst_busy |->
		line.alarm_insert == ($past(los_in, 2)
		& {8{$past(s.global_configuration[`LU_B_AINS])}}))
		else $error("alarm insertion wrong");
	AST_SPD: assert property (gcfg_wr ##1 ce |=>
		line.short_protect_disable == $past(hwdata[`LU_B_SPD], 2))
		else $error("short protect disable wrong");
	AST_AMI: assert property (gcfg_wr ##1 ce |=>
		line.ami_select == $past(hwdata[`LU_B_AMI], 2))
		else $error("line code select wrong");
	AST_JDEP: assert property (gcfg_wr ##1 ce |=>
		line.jitter_depth_select == $past(hwdata[`LU_B_JDEP], 2))
		else $error("jitter depth wrong");
	AST_JBW: assert property (gcfg_wr ##1 ce |=>
		line.jitter_bandwidth_select == $past(hwdata[`LU_B_JBW], 2))
		else $error("jitter bandwidth wrong");
	AST_JA: assert property (gcfg_wr ##1 ce |=>
		{line.ja_rx, line.ja_tx} == {$past(hwdata[1:0], 2) == `LU_JA_RX,
		$past(hwdata[1:0], 2) == `LU_JA_TX})
		else $error("jitter placement wrong");
	AST_TIDX_RD: assert property (ce && take && !hwrite && hit && aidx == `LU_IDX_TIDX |=>
		hrdata[31:3] == 29'h0 && hrdata[2:0] == $past(s.template_channel_index))
		else $error("template index read wrong");
	AST_HIZ: assert property (hiz_wr ##1 ce |=>
		line.driver_highz == $past(hwdata[7:0], 2))
		else $error("driver high-Z wrong");
	AST_ALST_RD: assert property (alst_rd |=>
		hrdata[7:0] == $past(s.alarm_status) && hrdata[31:8] == 24'h0)
		else $error("alarm status read wrong");
	AST_MASKED: assert property (ce_hist[0] |->
		(s.alarm_interrupt_latch & ~$past(s.alarm_interrupt_latch)
		& ~$past(s.alarm_interrupt_mask)) == 8'h00)
		else $error("masked channel latched");
	AST_RD_CLR: assert property (alst_rd && !srst_busy && !srst_load |=>
		s.alarm_interrupt_latch == $past(set_v))
		else $error("latch not cleared by read");
	AST_SRST: assert property (srst_go |=>
		s.srst_cnt == 9'(`LU_SRST_CYC) && s.global_configuration == `LU_RST8)
		else $error("software reset not started");
	AST_IRQ: assert property (ce_hist[0] |->
		irq == |$past(s.alarm_interrupt_latch))
		else $error("interrupt level wrong");

	COV_LATCH: cover property (ce && set_v != 8'h00 ##1 irq [*2]);
	COV_RD_CLR: cover property (alst_rd && s.alarm_interrupt_latch != 8'h00);
	COV_SRST: cover property (srst_go ##[1:300] s.srst_cnt == 9'h001);
	COV_ALL_ONES: cover property (line.all_ones_tx != 8'h00);
	COV_ALARM_INS: cover property (line.alarm_insert != 8'h00);

	////////////////////////////////////////////////////////////////
	// Further checks

	AST_TPL: assert property (ce_ok |->
		line.template_code == $past(s.template_select))
		else $error("template code output wrong");

	AST_TSEL_RD: assert property (ce && take && !hwrite && hit && aidx == `LU_IDX_TSEL |=>
		hrdata[31:3] == 29'h0
		&& hrdata[2:0] == $past(s.template_select[s.template_channel_index]))
		else $error("template select read wrong");

	AST_LOS_RD: assert property (ce && take && !hwrite && hit && aidx == `LU_IDX_LOS |=>
		hrdata == {24'h0, $past(s.los_status)})
		else $error("loss of signal read wrong");

	AST_LOS_CAP: assert property (ce |=>
		s.los_status == $past(los_in))
		else $error("loss of signal not captured");

	AST_ALST_CAP: assert property (ce |=>
		s.alarm_status == $past(alarm_in))
		else $error("alarm status not captured");

	AST_MASK_WR: assert property (ce && s.wr_pend && !srst_busy
		&& s.wr_idx == `LU_IDX_MASK |=>
		s.alarm_interrupt_mask == $past(hwdata[7:0]))
		else $error("mask write lost");

	AST_AAO_WR: assert property (ce && s.wr_pend && !srst_busy
		&& s.wr_idx == `LU_IDX_AAO |=>
		s.auto_all_ones_enable == $past(hwdata[7:0]))
		else $error("all ones enable write lost");

	AST_SET: assert property (ce && !srst_busy && !srst_load |=>
		(s.alarm_interrupt_latch & $past(set_v)) == $past(set_v))
		else $error("alarm transition not latched");

	AST_W1C: assert property (ce && s.wr_pend && !srst_busy && !alst_rd
		&& s.wr_idx == `LU_IDX_LATCH |=>
		s.alarm_interrupt_latch == (($past(s.alarm_interrupt_latch)
		& ~$past(hwdata[7:0])) | $past(set_v)))
		else $error("latch write clear wrong");

	AST_SRST_HOLD: assert property (ce && (srst_busy || srst_load) |=>
		s.alarm_interrupt_mask == `LU_RST8 && s.driver_highz_control == `LU_RST8
		&& s.auto_all_ones_enable == `LU_RST8 && s.alarm_interrupt_latch == `LU_RST8)
		else $error("registers not held at default");

	AST_SRST_CNT: assert property (ce && srst_busy |=>
		s.srst_cnt == $past(s.srst_cnt) - 9'h001)
		else $error("software reset count wrong");

	AST_GCFG_RSV: assert property (s.global_configuration[7] == 1'b0)
		else $error("reserved configuration bit set");

	AST_UNMAPPED_RD: assert property (ce && take && !hwrite && !hit |=>
		hrdata == 32'h00000000)
		else $error("unmapped read not zero");

	AST_IDLE_RD: assert property (ce && !(take && !hwrite) |=>
		hrdata == 32'h00000000)
		else $error("read data not released");

	AST_OKAY: assert property (hresp == 1'b0 && hreadyout == 1'b1)
		else $error("bus response not okay");

	AST_FREEZE: assert property (!ce |=> $stable(s))
		else $error("state moved while clock enable low");

endmodule

// *** rtl/lu_params.svh ***
`ifndef LU_PARAMS_SVH
`define LU_PARAMS_SVH

// Register word indices, byte address is index times four
`define LU_IDX_LOS   6'h04
`define LU_IDX_SRST  6'h0A
`define LU_IDX_AAO   6'h0E
`define LU_IDX_GCFG  6'h0F
`define LU_IDX_TIDX  6'h10
`define LU_IDX_TSEL  6'h11
`define LU_IDX_HIZ   6'h12
`define LU_IDX_ALST  6'h13
`define LU_IDX_MASK  6'h14
`define LU_IDX_LATCH 6'h15

// Reset values
`define LU_RST8      8'h00
`define LU_RST3      3'h0

// Global configuration fields
`define LU_GCFG_WMASK 8'h7F
`define LU_B_AINS    6
`define LU_B_SPD     5
`define LU_B_AMI     4
`define LU_B_JDEP    3
`define LU_B_JBW     2
`define LU_JA_HI     1
`define LU_JA_LO     0
`define LU_JA_TX     2'h1
`define LU_JA_RX     2'h3

// Software reset time
`define LU_SRST_NS   1000
`define LU_CLK_MHZ   250
`define LU_SRST_CYC  ((`LU_SRST_NS * `LU_CLK_MHZ + 999) / 1000)

`endif

// *** rtl/lu_pkg.sv ***
package lu_pkg;

	typedef struct packed {
		logic [7:0]      all_ones_tx;
		logic [7:0]      alarm_insert;
		logic [7:0]      driver_highz;
		logic [7:0][2:0] template_code;
		logic            short_protect_disable;
		logic            ami_select;
		logic            jitter_depth_select;
		logic            jitter_bandwidth_select;
		logic            ja_tx;
		logic            ja_rx;
	} lu_line_s;

	typedef struct packed {
		logic [7:0]      auto_all_ones_enable;
		logic [7:0]      global_configuration;
		logic [2:0]      template_channel_index;
		logic [7:0][2:0] template_select;
		logic [7:0]      driver_highz_control;
		logic [7:0]      alarm_status;
		logic [7:0]      alarm_interrupt_mask;
		logic [7:0]      alarm_interrupt_latch;
		logic [7:0]      los_status;
		logic [8:0]      srst_cnt;
		logic            wr_pend;
		logic [5:0]      wr_idx;
		logic [31:0]     hrdata;
		logic            hreadyout;
		logic            irq;
		lu_line_s        line;
	} lu_state_s;

endpackage

// *** verif/line_unit_config_alarm_regs_tb.sv ***
`include "lu_params.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module line_unit_config_alarm_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import lu_pkg::*;

	logic        hclk;
	logic        hresetn;
	logic        ce;
	logic        hsel;
	logic        hwrite;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [7:0]  los_in;
	logic [7:0]  alarm_in;
	lu_line_s    line;
	logic        irq;
	int          num_errors;
	int          checks_done;
	int          cycles;
	int          seed;
	logic [31:0] rd;
	logic [7:0]  v;
	logic [7:0]  aao;

	lu_regs DUT (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.ce        (ce),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hreadyout),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.los_in    (los_in),
		.alarm_in  (alarm_in),
		.line      (line),
		.irq       (irq)
	);

	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	always @(posedge hclk) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task complete_run;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Wait for hready high as sampled at the coming rising edge
	task automatic wait_rdy;
		do @(negedge hclk); while (hreadyout !== 1'b1);
	endtask

	task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, idx, 2'h0};
		hwrite <= wr;
		htrans <= 2'h2;
		wait_rdy();
		@(posedge hclk);
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		wait_rdy();
		rd = hrdata;
		@(posedge hclk);
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
	endtask

	task automatic rdchk(input logic [5:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00);
		`CHK(rd, {24'h0, e})
	endtask

	function automatic logic [1:0] ja_exp(input logic [1:0] c);
		return {c == 2'h3, c == 2'h1};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 98;
		hresetn = 1'b0;
		ce = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		los_in = 8'h00;
		alarm_in = 8'h00;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// Reset values
		for (int i = 14; i < 22; i++) rdchk(6'(i), 8'h00);
		`CHK(line, lu_line_s'(0))
		// Global configuration, every placement code first
		for (int k = 0; k < 12; k++) begin
			v = 8'($random(seed));
			if (k < 4) v[1:0] = 2'(k);
			wr(`LU_IDX_GCFG, v);
			rdchk(`LU_IDX_GCFG, v & `LU_GCFG_WMASK);
			`CHK(line.short_protect_disable, v[`LU_B_SPD])
			`CHK(line.ami_select, v[`LU_B_AMI])
			`CHK(line.jitter_depth_select, v[`LU_B_JDEP])
			`CHK(line.jitter_bandwidth_select, v[`LU_B_JBW])
			`CHK({line.ja_rx, line.ja_tx}, ja_exp(v[1:0]))
			wr(`LU_IDX_HIZ, v ^ 8'hA5);
			rdchk(`LU_IDX_HIZ, v ^ 8'hA5);
			`CHK(line.driver_highz, v ^ 8'hA5)
		end
		// Templates through the channel index, reserved index bits set
		for (int i = 0; i < 8; i++) begin
			wr(`LU_IDX_TIDX, {5'h15, 3'(i)});
			wr(`LU_IDX_TSEL, {5'h00, 3'(i) ^ 3'h5});
		end
		for (int i = 7; i >= 0; i--) begin
			wr(`LU_IDX_TIDX, 8'(i));
			rdchk(`LU_IDX_TIDX, 8'(i));
			rdchk(`LU_IDX_TSEL, {5'h00, 3'(i) ^ 3'h5});
			`CHK(line.template_code[i], 3'(i) ^ 3'h5)
		end
		// Unmapped places
		wr(6'h20, 8'hFF);
		rdchk(6'h20, 8'h00);
		rdchk(6'h3F, 8'h00);
		// Loss of signal, all ones and alarm insertion
		aao = 8'($random(seed));
		wr(`LU_IDX_AAO, aao);
		rdchk(`LU_IDX_AAO, aao);
		wr(`LU_IDX_GCFG, 8'h40);
		for (int k = 0; k < 6; k++) begin
			los_in <= 8'($random(seed));
			repeat (3) @(posedge hclk);
			rdchk(`LU_IDX_LOS, los_in);
			`CHK(line.all_ones_tx, los_in & aao)
			`CHK(line.alarm_insert, los_in)
		end
		wr(`LU_IDX_GCFG, 8'h00);
		rdchk(`LU_IDX_GCFG, 8'h00);
		`CHK(line.alarm_insert, 8'h00)
		// Alarm latch, mask and interrupt
		wr(`LU_IDX_MASK, 8'h0F);
		rdchk(`LU_IDX_MASK, 8'h0F);
		alarm_in <= 8'hFF;
		repeat (3) @(posedge hclk);
		`CHK(irq, 1'b1)
		rdchk(`LU_IDX_LATCH, 8'h0F);
		rdchk(`LU_IDX_ALST, 8'hFF);
		rdchk(`LU_IDX_LATCH, 8'h00);
		`CHK(irq, 1'b0)
		alarm_in <= 8'h7E;
		repeat (3) @(posedge hclk);
		rdchk(`LU_IDX_LATCH, 8'h01);
		wr(`LU_IDX_LATCH, 8'h01);
		rdchk(`LU_IDX_LATCH, 8'h00);
		// Software reset
		wr(`LU_IDX_AAO, 8'h3C);
		wr(`LU_IDX_SRST, 8'h5A);
		rdchk(`LU_IDX_AAO, 8'h00);
		wr(`LU_IDX_AAO, 8'h11);
		repeat (`LU_SRST_CYC) @(posedge hclk);
		rdchk(`LU_IDX_AAO, 8'h00);
		rdchk(`LU_IDX_MASK, 8'h00);
		wr(`LU_IDX_AAO, 8'h11);
		rdchk(`LU_IDX_AAO, 8'h11);
		complete_run();
	end
endmodule
